//--- inc/uart_irq_pkg.sv
// Shared constants and types for the serial port interrupt status block
package uart_irq_pkg;

  // Bus geometry
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          NUM_SRC      = 11;
  localparam int          RAW_W        = 12;

  // Register byte offsets
  localparam logic [11:0] MASK_OFF     = 12'h038;
  localparam logic [11:0] RAW_OFF      = 12'h03c;
  localparam logic [11:0] MASKED_OFF   = 12'h040;
  localparam logic [11:0] CLEAR_OFF    = 12'h044;
  localparam logic [11:0] TEST_OFF     = 12'h080;

  // Reset values
  localparam logic [10:0] MASK_RESET   = 11'h000;
  localparam logic [10:0] RAW_RESET    = 11'h000;
  localparam logic [2:0]  TEST_RESET   = 3'h0;

  // Test control field positions
  localparam int          INFRARED_TEST_BIT = 2;
  localparam int          QUEUE_TEST_BIT    = 1;
  localparam int          INTEG_TEST_BIT    = 0;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // One bit per interrupt source, bit 10 first down to bit 0
  typedef struct packed {
    logic overrunIrq;
    logic breakIrq;
    logic parityIrq;
    logic framingIrq;
    logic rxTimeoutIrq;
    logic transmitIrq;
    logic receiveIrq;
    logic dataSetReadyIrq;
    logic carrierDetectIrq;
    logic clearToSendIrq;
    logic ringIndicatorIrq;
  } irq_vec_s;

  // Test control bits, bit 2 first
  typedef struct packed {
    logic infraredTestEnable;
    logic queueTestEnable;
    logic integrationTestEnable;
  } test_ctrl_s;

  // Whole state of the block
  typedef struct packed {
    logic              awTaken;
    logic [ADDR_W-1:0] awAddr;
    logic              wTaken;
    logic [DATA_W-1:0] wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0]        rResp;
    irq_vec_s          mask;
    irq_vec_s          raw;
    test_ctrl_s        test;
  } ctrl_state_s;

endpackage : uart_irq_pkg

//--- rtl/uart_irq_status.sv
// Interrupt mask, raw and masked status, and clear logic of a serial port, on AXI4-Lite
//
// Operation
// R1 - Mask bits 10 to 3 (overrun, break, parity, framing, rx timeout, transmit, receive, data set ready) are read/write.
// R2 - Mask bit 2 enables the carrier detect interrupt, resets to zero and is read/write.
// R3 - Mask bit 1 enables the clear to send interrupt, resets to zero and is read/write.
// R4 - Mask bit 0 enables the ring indicator interrupt, resets to zero and is read/write.
// R5 - Raw status bits 10 to 7 show overrun, break, parity and framing errors regardless of mask.
// R6 - Raw status bits 6 to 4 show rx timeout, transmit and receive regardless of mask.
// R7 - Raw status bits 3 to 0 show the four modem line interrupts regardless of mask.
// R8 - Masked status bits 10 to 7 show the masked error interrupts.
// R9 - Masked status bits 6 to 4 show masked rx timeout, transmit and receive.
// R10 - Masked status bits 3 to 0 show the masked modem interrupts.
// R11 - Writing ones to clear bits 10 to 7 clears the matching error interrupts.
// R12 - Writing ones to clear bits 6 to 4 clears rx timeout, transmit and receive.
// R13 - Writing ones to clear bits 3 to 0 clears the matching modem interrupts.
// R14 - Each masked bit is its raw bit AND its mask bit, and these drive the combined output.
// R15 - Clear bits written as zero leave their raw interrupts unchanged.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module uart_irq_status
  import uart_irq_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            awvalid,
  output      logic                            awready,
  input  wire logic [uart_irq_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                            wvalid,
  output      logic                            wready,
  input  wire logic [uart_irq_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                      wstrb,
  output      logic                            bvalid,
  input  wire logic                            bready,
  output      logic [1:0]                      bresp,
  input  wire logic                            arvalid,
  output      logic                            arready,
  input  wire logic [uart_irq_pkg::ADDR_W-1:0] araddr,
  output      logic                            rvalid,
  input  wire logic                            rready,
  output      logic [uart_irq_pkg::DATA_W-1:0] rdata,
  output      logic [1:0]                      rresp,
  input  wire uart_irq_pkg::irq_vec_s          events,
  output      uart_irq_pkg::irq_vec_s          maskedIrq,
  output      logic                            irq,
  output      uart_irq_pkg::test_ctrl_s        testCtrl
);
  import uart_irq_pkg::*;

  ctrl_state_s       s_q;
  ctrl_state_s       s_d;
  logic              wrDo;
  logic [DATA_W-1:0] merged;
  logic [DATA_W-1:0] cleared;
  logic [NUM_SRC-1:0] clearBits;
  logic [NUM_SRC-1:0] maskedVec;

  // Word-aligned address compare, shared by the read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction : hit

  // Replace only the byte lanes that the strobes select
  function automatic logic [DATA_W-1:0] mergeStrobe(input logic [DATA_W-1:0] old,
                                                     input logic [DATA_W-1:0] nw,
                                                     input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : mergeStrobe

  // Handshakes: one write and one read in flight; answer must drain first
  assign awready   = ~s_q.awTaken & ~s_q.bValid;
  assign wready    = ~s_q.wTaken & ~s_q.bValid;
  assign arready   = ~s_q.rValid;
  assign wrDo      = s_q.awTaken & s_q.wTaken & ~s_q.bValid;
  assign bvalid    = s_q.bValid;
  assign bresp     = s_q.bResp;
  assign rvalid    = s_q.rValid;
  assign rdata     = s_q.rData;
  assign rresp     = s_q.rResp;
  assign testCtrl  = s_q.test;

  // Masked view and combined output, both straight from the status flops
  assign maskedVec = s_q.raw & s_q.mask; // R14
  assign maskedIrq = irq_vec_s'(maskedVec); // R8 R9 R10
  assign irq       = |maskedVec; // R14

  // Next state of bus channels and registers
  always_comb
  begin
    s_d       = s_q;
    merged    = '0;
    cleared   = '0;
    clearBits = '0;

    // Address and data are captured independently, in either order
    if (awvalid && awready)
    begin
      s_d.awTaken = 1'b1;
      s_d.awAddr  = awaddr;
    end
    if (wvalid && wready)
    begin
      s_d.wTaken = 1'b1;
      s_d.wData  = wdata;
      s_d.wStrb  = wstrb;
    end
    if (s_q.bValid && bready)
    begin
      s_d.bValid = 1'b0;
    end

    // Perform the write once both halves are held
    if (wrDo)
    begin
      s_d.awTaken = 1'b0;
      s_d.wTaken  = 1'b0;
      s_d.bValid  = 1'b1;
      s_d.bResp   = RESP_OKAY;
      if (hit(s_q.awAddr, MASK_OFF))
      begin
        merged   = mergeStrobe({{(DATA_W-NUM_SRC){1'b0}}, s_q.mask}, s_q.wData, s_q.wStrb);
        s_d.mask = irq_vec_s'(merged[NUM_SRC-1:0]); // R1 R2 R3 R4
      end
      else if (hit(s_q.awAddr, CLEAR_OFF))
      begin
        // Only ones in enabled lanes clear; zeros are no-ops
        cleared   = mergeStrobe('0, s_q.wData, s_q.wStrb);
        clearBits = cleared[NUM_SRC-1:0]; // R11 R12 R13 R15
      end
      else if (hit(s_q.awAddr, TEST_OFF))
      begin
        merged   = mergeStrobe({{(DATA_W-3){1'b0}}, s_q.test}, s_q.wData, s_q.wStrb);
        s_d.test = test_ctrl_s'(merged[2:0]);
      end
      else if (!hit(s_q.awAddr, RAW_OFF) && !hit(s_q.awAddr, MASKED_OFF))
      begin
        // Status registers silently ignore writes; holes answer with an error
        s_d.bResp = RESP_SLVERR;
      end
    end

    // Set beats clear so an event in the clearing cycle is never lost
    s_d.raw = irq_vec_s'((s_q.raw & ~clearBits) | events); // R5 R6 R7 R11 R12 R13 R15

    // Read channel: data registered one cycle after the address
    if (s_q.rValid && rready)
    begin
      s_d.rValid = 1'b0;
    end
    if (arvalid && arready)
    begin
      s_d.rValid = 1'b1;
      s_d.rResp  = RESP_OKAY;
      s_d.rData  = '0;
      if (hit(araddr, MASK_OFF))
      begin
        s_d.rData[NUM_SRC-1:0] = s_q.mask; // R1 R2 R3 R4
      end
      else if (hit(araddr, RAW_OFF))
      begin
        s_d.rData[NUM_SRC-1:0] = s_q.raw; // R5 R6 R7
      end
      else if (hit(araddr, MASKED_OFF))
      begin
        s_d.rData[NUM_SRC-1:0] = maskedVec; // R8 R9 R10 R14
      end
      else if (!hit(araddr, CLEAR_OFF) && !hit(araddr, TEST_OFF))
      begin
        // Write-only registers read as zero; holes answer with an error
        s_d.rResp = RESP_SLVERR;
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q      <= '0;
      s_q.mask <= irq_vec_s'(MASK_RESET); // R2 R3 R4
      s_q.raw  <= irq_vec_s'(RAW_RESET);
      s_q.test <= test_ctrl_s'(TEST_RESET);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Full-word mask write lands in the mask one edge later
  AST_MASK_WRITE: assert property (@(posedge clk) disable iff (rst) // R1 R2 R3 R4
    wrDo && hit(s_q.awAddr, MASK_OFF) && s_q.wStrb == 4'hf
    |=> s_q.mask == $past(s_q.wData[NUM_SRC-1:0]))
    else $error("mask did not take written value");

  // Mask is zero on the first edge after reset
  AST_MASK_RESET: assert property (@(posedge clk) disable iff (rst) // R2 R3 R4
    $past(rst) |-> s_q.mask == MASK_RESET)
    else $error("mask not cleared by reset");

  // Every event shows in raw status on the next edge, whatever the mask
  AST_EVENT_SETS_RAW: assert property (@(posedge clk) disable iff (rst) // R5 R6 R7
    events != '0 |=> (s_q.raw & $past(events)) == $past(events))
    else $error("event missing from raw status");

  // Raw read returns the raw bits held at the address edge
  AST_RAW_READ: assert property (@(posedge clk) disable iff (rst) // R5 R6 R7
    arvalid && arready && hit(araddr, RAW_OFF)
    |=> rvalid && rdata == {{(DATA_W-NUM_SRC){1'b0}}, $past(s_q.raw)})
    else $error("raw status read mismatch");

  // Masked read returns raw AND mask at the address edge
  AST_MASKED_READ: assert property (@(posedge clk) disable iff (rst) // R8 R9 R10 R14
    arvalid && arready && hit(araddr, MASKED_OFF)
    |=> rdata[NUM_SRC-1:0] == ($past(s_q.raw) & $past(s_q.mask)))
    else $error("masked status read mismatch");

  // An unmasked event raises the interrupt on the next edge when no write completes in the same cycle
  AST_IRQ_RAISE: assert property (@(posedge clk) disable iff (rst) // R14
    (events & s_q.mask) != '0 && !wrDo |=> irq)
    else $error("unmasked event did not raise interrupt");

  // Full-word clear write with no event removes every written-one bit
  AST_CLEAR_ONES: assert property (@(posedge clk) disable iff (rst) // R11 R12 R13
    wrDo && hit(s_q.awAddr, CLEAR_OFF) && s_q.wStrb == 4'hf && events == '0
    |=> (s_q.raw & $past(s_q.wData[NUM_SRC-1:0])) == '0)
    else $error("clear write left a bit set");

  // Zeros in a clear write leave those raw bits alone
  AST_CLEAR_ZEROS: assert property (@(posedge clk) disable iff (rst) // R15
    wrDo && hit(s_q.awAddr, CLEAR_OFF) && events == '0
    |=> (s_q.raw & ~$past(cleared[NUM_SRC-1:0])) == ($past(s_q.raw) & ~$past(cleared[NUM_SRC-1:0])))
    else $error("clear write disturbed an unwritten bit");

  // Event in the clearing cycle survives
  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst) // R11 R12 R13
    wrDo && hit(s_q.awAddr, CLEAR_OFF) && events != '0
    |=> (s_q.raw & $past(events)) == $past(events))
    else $error("event lost against clear");

  // Write answer two edges after both halves are taken together
  AST_WRITE_ANSWER: assert property (@(posedge clk) disable iff (rst) // R1
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");

  // Mask moves only through a mask write, never as a side effect
  AST_MASK_HOLD: assert property (@(posedge clk) disable iff (rst) // R1 R2 R3 R4
    !(wrDo && hit(s_q.awAddr, MASK_OFF)) |=> $stable(s_q.mask))
    else $error("mask changed without a mask write");

  // With no event and no clear the sticky bits stay put
  AST_RAW_HOLD: assert property (@(posedge clk) disable iff (rst) // R5 R6 R7 R15
    events == '0 && !(wrDo && hit(s_q.awAddr, CLEAR_OFF)) |=> $stable(s_q.raw))
    else $error("raw status changed on its own");

  // Mask read returns the mask held at the address edge
  AST_MASK_READ: assert property (@(posedge clk) disable iff (rst) // R1 R2 R3 R4
    arvalid && arready && hit(araddr, MASK_OFF)
    |=> rdata == {{(DATA_W-NUM_SRC){1'b0}}, $past(s_q.mask)})
    else $error("mask read mismatch");

  // Write-only registers read back as zero with a good answer
  AST_WO_READ_ZERO: assert property (@(posedge clk) disable iff (rst) // R11 R12 R13
    arvalid && arready && (hit(araddr, CLEAR_OFF) || hit(araddr, TEST_OFF))
    |=> rdata == '0 && rresp == RESP_OKAY)
    else $error("write-only register read not zero");

  // Holes in the map answer reads with an error and zero data
  AST_HOLE_READ: assert property (@(posedge clk) disable iff (rst) // R5 R8
    arvalid && arready && !hit(araddr, MASK_OFF) && !hit(araddr, RAW_OFF) && !hit(araddr, MASKED_OFF)
      && !hit(araddr, CLEAR_OFF) && !hit(araddr, TEST_OFF)
    |=> rdata == '0 && rresp == RESP_SLVERR)
    else $error("unmapped read not refused");

  // Bits above the eleven sources always read as zero
  AST_READ_TOP_ZERO: assert property (@(posedge clk) disable iff (rst) // R5 R8
    rvalid |-> rdata[DATA_W-1:NUM_SRC] == '0)
    else $error("read data above bit 10 not zero");

  // Every accepted read is answered on the next edge
  AST_READ_ANSWER: assert property (@(posedge clk) disable iff (rst) // R5 R8
    arvalid && arready |=> rvalid)
    else $error("read answer late");

  // Read answer stands until the master takes it
  AST_RVALID_HOLD: assert property (@(posedge clk) disable iff (rst) // R5 R8
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");

  // Write answer stands until the master takes it
  AST_BVALID_HOLD: assert property (@(posedge clk) disable iff (rst) // R1
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");

  // A pending answer blocks the next request on its channel
  AST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (rst) // R1
    bvalid |-> !awready && !wready)
    else $error("write accepted while answer pending");

  // A pending read answer blocks the next read address
  AST_READ_REFUSED: assert property (@(posedge clk) disable iff (rst) // R5
    rvalid |-> !arready)
    else $error("read accepted while answer pending");

  // Writes to status registers are ignored but answered as good
  AST_STATUS_WRITE_IGNORED: assert property (@(posedge clk) disable iff (rst) // R5 R8
    wrDo && (hit(s_q.awAddr, RAW_OFF) || hit(s_q.awAddr, MASKED_OFF))
    |=> bvalid && bresp == RESP_OKAY && $stable(s_q.mask))
    else $error("status register write not ignored");

  // Writes to holes are refused and change no register
  AST_HOLE_WRITE: assert property (@(posedge clk) disable iff (rst) // R1
    wrDo && !hit(s_q.awAddr, MASK_OFF) && !hit(s_q.awAddr, RAW_OFF) && !hit(s_q.awAddr, MASKED_OFF)
      && !hit(s_q.awAddr, CLEAR_OFF) && !hit(s_q.awAddr, TEST_OFF)
    |=> bvalid && bresp == RESP_SLVERR && $stable(s_q.mask))
    else $error("unmapped write not refused");

  // Clearing all sources with no event pending drops the interrupt
  AST_IRQ_CLEARED: assert property (@(posedge clk) disable iff (rst) // R11 R12 R13 R14
    wrDo && hit(s_q.awAddr, CLEAR_OFF) && s_q.wStrb == 4'hf && s_q.wData[NUM_SRC-1:0] == '1 && events == '0
    |=> !irq)
    else $error("interrupt still high after full clear");

  // First edge after reset sees idle status and idle bus
  AST_RESET_STATE: assert property (@(posedge clk) disable iff (rst) // R5 R6 R7
    $past(rst) |-> s_q.raw == RAW_RESET && !bvalid && !rvalid && awready && arready && testCtrl == TEST_RESET)
    else $error("state not idle after reset");

endmodule : uart_irq_status

//--- sim/uart_irq_peer.sv
// Model of the serial line and modem side that raises interrupt events
`timescale 1ns/100ps
module uart_irq_peer
  import uart_irq_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   go,
  input  wire logic                   slow,
  input  wire uart_irq_pkg::irq_vec_s request,
  output      uart_irq_pkg::irq_vec_s events
);
  logic stretch = 1'b0;

  initial events = '0;

  // One-cycle event pulse, two cycles when the line is slow to settle
  always @(posedge clk)
  begin
    stretch <= go && slow;
    if (go)
      events <= request;
    else if (!stretch)
      events <= '0;
  end
endmodule : uart_irq_peer

//--- sim/uart_irq_status_bench.sv
// Self-checking bench for the serial port interrupt status block
`timescale 1ns/100ps
module uart_irq_status_bench;
  import uart_irq_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, go = 1'b0, slow = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp;
  irq_vec_s    request = '0, events, maskedIrq, expRaw = '0, expMask = '0, clr;
  test_ctrl_s  testCtrl;
  int          seed = 75, fails = 0, totalChecks = 0;

  // Half period of 10 ns gives 50 MHz
  always #10 clk = ~clk;

  uart_irq_status uart_irq_status_inst (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .events(events),
    .maskedIrq(maskedIrq), .irq(irq), .testCtrl(testCtrl));

  uart_irq_peer uart_irq_peer_inst (.clk(clk), .go(go), .slow(slow), .request(request), .events(events));

  // Expected masked view, worked out independently of the design
  function automatic logic [31:0] masked(input irq_vec_s r, input irq_vec_s m);
    masked = {21'h0, r & m};
  endfunction : masked

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
    @(posedge clk);
  endtask : rd

  // Ask the peer for one event burst, then let the sticky bits land
  task automatic fire(input irq_vec_s v, input logic s);
    request <= v;
    slow <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    expRaw = expRaw | v;
  endtask : fire

  // Hang guard, far beyond the length of the sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(MASK_OFF, 32'h0, RESP_OKAY);
    rd(RAW_OFF, 32'h0, RESP_OKAY);
    rd(MASKED_OFF, 32'h0, RESP_OKAY);
    chk(irq, 1'b0);
    // Walk a single one through every mask position
    for (int i = 0; i < 11; i++)
    begin
      wr(MASK_OFF, 32'h1 << i, RESP_OKAY);
      rd(MASK_OFF, 32'h1 << i, RESP_OKAY);
    end
    // Only the strobed byte lane of a mask write lands
    wr(MASK_OFF, 32'h7ff, RESP_OKAY);
    wstrb <= 4'h1;
    wr(MASK_OFF, 32'h0, RESP_OKAY);
    wstrb <= 4'hf;
    rd(MASK_OFF, 32'h700, RESP_OKAY);
    // Random masks, events and clears; slow pulses on odd rounds
    for (int k = 0; k < 24; k++)
    begin
      expMask = irq_vec_s'(NUM_SRC'($random(seed)));
      wr(MASK_OFF, {21'h0, expMask}, RESP_OKAY);
      fire(irq_vec_s'(NUM_SRC'($random(seed))), k[0]);
      rd(RAW_OFF, {21'h0, expRaw}, RESP_OKAY);
      rd(MASKED_OFF, masked(expRaw, expMask), RESP_OKAY);
      chk({21'h0, maskedIrq}, masked(expRaw, expMask));
      chk(irq, |masked(expRaw, expMask));
      clr = irq_vec_s'(NUM_SRC'($random(seed)));
      wr(CLEAR_OFF, {21'h0, clr}, RESP_OKAY);
      expRaw = expRaw & ~clr;
      rd(RAW_OFF, {21'h0, expRaw}, RESP_OKAY);
    end
    // Reset in mid-run returns mask, raw bits and interrupt to idle
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(MASK_OFF, 32'h0, RESP_OKAY);
    rd(RAW_OFF, 32'h0, RESP_OKAY);
    chk(irq, 1'b0);
    // All sources set, a zero clear must change nothing
    fire(11'h7ff, 1'b0);
    wr(CLEAR_OFF, 32'h0, RESP_OKAY);
    rd(RAW_OFF, 32'h7ff, RESP_OKAY);
    // Status registers ignore writes; clear register reads back zero
    wr(RAW_OFF, 32'h0, RESP_OKAY);
    wr(MASKED_OFF, 32'h0, RESP_OKAY);
    rd(RAW_OFF, 32'h7ff, RESP_OKAY);
    rd(CLEAR_OFF, 32'h0, RESP_OKAY);
    // A clear in one byte lane leaves the other lanes set
    wstrb <= 4'h2;
    wr(CLEAR_OFF, 32'h7ff, RESP_OKAY);
    wstrb <= 4'hf;
    rd(RAW_OFF, 32'h0ff, RESP_OKAY);
    wr(CLEAR_OFF, 32'h7ff, RESP_OKAY);
    rd(RAW_OFF, 32'h0, RESP_OKAY);
    chk(irq, 1'b0);
    // An event that arrives in the clearing cycle survives the clear
    fork
      wr(CLEAR_OFF, 32'h7ff, RESP_OKAY);
      fire(11'h155, 1'b0);
    join
    rd(RAW_OFF, 32'h155, RESP_OKAY);
    // Unmapped place answers with an error and zero data
    wr(12'h100, 32'hffffffff, RESP_SLVERR);
    rd(12'h100, 32'h0, RESP_SLVERR);
    wr(TEST_OFF, 32'h5, RESP_OKAY);
    chk(testCtrl, 3'h5);
    end_of_test();
  end
endmodule : uart_irq_status_bench
